// ==== common/mmd_pkg.sv ====
// What this block does
// (R1) 16 MB: 256 segments, four 16 KB pages
// (R2) One linear map; flash, SRAM, external starts
// (R3) Byte and word access everywhere
// (R4) Data memories and register areas in segment 0
// (R5) Top 256 DUAL_PORT_RAM bytes, register portions bit-addressable
// (R6) Active bank DUAL_PORT_RAM locations bit-addressable
// (R7) Bank: 16 words or byte pairs
// (R8) Fetches go through program unit
// (R9) Data transfers go through data unit
// (R10) System bus joins both units
// (R11) Serial and CAN ranges go via bus controller
// (R12) Reserved areas become external accesses; code does so only with an external bus, otherwise they fault
// (R13) External IO disables pipeline optimizations
// (R14) Top flash sector of segment 0 blocked
// (R15) Protected program SRAM portion blocks writes
// (R16) 4 KB sectors, clustered for protection
// (R17) Sector write-protect; 128-byte programming blocks
// (R18) 128-bit flash reads, always error-corrected
// (R19) Flash read protection, password unlocks
// (R20) Flash modules accessed in parallel
// (R21) Parity: single-bit error detected, data blocked
// (R22) ECC: single-bit error corrected
// (R23) Software leaves unused register addresses alone
// (R24) Combinational one-hot decode, registered result
package mmd_pkg;
  // Region start addresses
  localparam logic [23:0] A_DATA_SRAM = 24'h008000;
  localparam logic [23:0] A_XREG = 24'h00e000;
  localparam logic [23:0] A_EREG = 24'h00f000;
  localparam logic [23:0] A_RSV_DP = 24'h00f200;
  localparam logic [23:0] A_DUAL_PORT_RAM = 24'h00f600;
  localparam logic [23:0] A_SREG = 24'h00fe00;
  localparam logic [23:0] A_EXT1 = 24'h010000;
  localparam logic [23:0] A_CAN = 24'h200000;
  localparam logic [23:0] A_SER = 24'h204000;
  localparam logic [23:0] A_RSV_P0 = 24'h206800;
  localparam logic [23:0] A_CAN_ALT = 24'h208000;
  localparam logic [23:0] A_RSV_P1 = 24'h20c000;
  localparam logic [23:0] A_EXT_IO = 24'h210000;
  localparam logic [23:0] A_EXT_MEM = 24'h400000;
  localparam logic [23:0] A_FLASH = 24'hc00000;
  localparam logic [23:0] A_RSV_FL = 24'hd90000;
  localparam logic [23:0] A_PROGRAM_SRAM = 24'he00000;
  localparam logic [23:0] A_RSV_PS = 24'he1c000;
  localparam logic [23:0] A_EMULATED_PROGRAM_SRAM = 24'he80000;
  localparam logic [23:0] A_RSV_EP = 24'he9c000;
  localparam logic [23:0] A_RSV_TOP = 24'hf00000;
  localparam logic [23:0] A_IMB = 24'hffff00;
  // Protected and bit-addressable windows
  localparam logic [23:0] A_FL_RES = 24'hc0f000;
  localparam logic [23:0] A_FL_RES_END = 24'hc10000;
  localparam logic [23:0] A_DP_BIT = 24'h00fd00;
  localparam logic [23:0] A_SREG_BIT = 24'h00ff00;
  localparam logic [23:0] A_EREG_BIT = 24'h00f100;
  localparam logic [15:0] GPR_SPAN = 16'h0020;
  // Address field positions
  localparam int SEG_LSB = 16;
  localparam int PAGE_LSB = 14;
  localparam int FL_MOD_LSB = 18;
  localparam int FL_CL_LSB = 16;
  localparam int FL_SEC_LSB = 12;
  localparam int FL_BLK_LSB = 7;
  localparam int FL_LINE_LSB = 4;
  // Memory protection modes
  localparam logic [1:0] PROT_OFF = 2'h0;
  localparam logic [1:0] PROT_PAR = 2'h1;
  localparam logic [1:0] PROT_ECC = 2'h2;
  // Hamming positions of the 16 data bits
  localparam logic [4:0] HAM_POS [16] = '{5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0c,
    5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};

  typedef enum logic [13:0] {
    T_EXT_MEM = 14'h0001, T_EXT_IO = 14'h0002, T_PERIPH = 14'h0004,
    T_DATA_SRAM = 14'h0008, T_XREG = 14'h0010, T_EREG = 14'h0020,
    T_DUAL_PORT_RAM = 14'h0040, T_SREG = 14'h0080, T_FLASH = 14'h0100,
    T_PROGRAM_SRAM = 14'h0200, T_EMULATED_PROGRAM_SRAM = 14'h0400, T_IMB = 14'h0800,
    T_NONE = 14'h1000, T_RSV = 14'h2000
  } mmd_tgt_t;

  typedef enum logic [2:0] {
    PW_LOCKED = 3'b001, PW_HALF = 3'b010, PW_OPEN = 3'b100
  } mmd_pw_t;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic word;
    logic [23:0] addr;
  } mmd_req_t;

  typedef struct packed {
    logic valid;
    mmd_tgt_t target;
    logic fault;
    logic via_pmu;
    logic sysbus;
    logic via_ebc;
    logic no_pipe_opt;
    logic bit_addr;
    logic gpr_hit;
    logic [3:0] gpr_idx;
    logic gpr_hi;
    logic word;
    logic [7:0] segment;
    logic [1:0] page;
    logic [2:0] fl_module;
    logic [5:0] fl_sector;
    logic [4:0] fl_block;
    logic [19:0] fl_line;
  } mmd_dec_t;

  // Data bits covered by Hamming check bit k
  function automatic logic [15:0] mmd_mask(input int k);
    logic [15:0] m;
    logic [4:0] p;
    m = '0;
    for (int i = 0; i < 16; i++) begin
      p = HAM_POS[i];
      m[i] = p[k];
    end
    return m;
  endfunction : mmd_mask
endpackage : mmd_pkg

// ==== logic/mmd_mem_check.sv ====
`timescale 1ns/1ps
module mmd_mem_check (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Raw memory word
  input wire logic i_valid,
  input wire logic [15:0] i_data,
  input wire logic [5:0] i_check,
  input wire logic [1:0] i_mode,
  // Checked word
  output logic o_valid,
  output logic [15:0] o_data,
  output logic o_error,
  output logic o_corrected
);
  logic [4:0] syn_calc;
  logic [4:0] syndrome;
  logic [15:0] flip;
  logic par_bad;
  logic all_par;
  logic ecc_single;
  logic ecc_double;
  logic err_d;
  logic [15:0] data_d;
  logic valid_q;
  logic [15:0] data_q;
  logic err_q;
  logic fix_q;

  // Syndrome bits from the data
  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_syn
      assign syn_calc[k] = ^(i_data & mmd_pkg::mmd_mask(k));
    end
  endgenerate

  // Bit to flip for each syndrome
  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : g_flip
      assign flip[b] = (syndrome == mmd_pkg::HAM_POS[b]);
    end
  endgenerate

  // Error classification per mode
  assign syndrome = syn_calc ^ i_check[4:0];
  assign par_bad = (^i_data) ^ i_check[5];
  assign all_par = (^i_data) ^ (^i_check);
  assign ecc_single = (syndrome != 5'h00) && all_par;
  assign ecc_double = (syndrome != 5'h00) && !all_par;
  assign err_d = (i_mode == mmd_pkg::PROT_PAR) ? par_bad : // R21
                 (i_mode == mmd_pkg::PROT_ECC) ? ecc_double : 1'b0;
  assign data_d = err_d ? 16'h0000 : // R21
                  (i_mode == mmd_pkg::PROT_ECC && ecc_single) ? (i_data ^ flip) : i_data; // R22

  // Output register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      valid_q <= 1'b0;
      data_q <= 16'h0000;
      err_q <= 1'b0;
      fix_q <= 1'b0;
    end else begin
      valid_q <= i_valid;
      data_q <= data_d;
      err_q <= i_valid && err_d;
      fix_q <= i_valid && (i_mode == mmd_pkg::PROT_ECC) && ecc_single;
    end
  end

  assign o_valid = valid_q;
  assign o_data = data_q;
  assign o_error = err_q;
  assign o_corrected = fix_q;

  // Parity fault hides the word
  AST_PAR_BLOCK: assert property (@(posedge i_clk) disable iff (i_rst) // R21
    i_valid && i_mode == mmd_pkg::PROT_PAR && par_bad |=> o_error && o_data == 16'h0000)
    else $error("parity error not blocked");
  // Single flipped bit repaired
  AST_ECC_FIX: assert property (@(posedge i_clk) disable iff (i_rst) // R22
    i_valid && i_mode == mmd_pkg::PROT_ECC && ecc_single |=> o_corrected && !o_error)
    else $error("single bit error not corrected");
endmodule : mmd_mem_check

// ==== logic/mmd_decoder.sv ====
`timescale 1ns/1ps
module mmd_decoder (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Access request from the core
  input wire mmd_pkg::mmd_req_t i_req,
  input wire logic [15:0] i_context_ptr,
  // Configuration
  input wire logic i_has_ext_bus,
  input wire logic [16:0] i_program_sram_wp_top,
  input wire logic [27:0] i_flash_wp,
  input wire logic i_flash_rd_prot,
  // Password unlock
  input wire logic i_pw_valid,
  input wire logic [15:0] i_pw_data,
  input wire logic [15:0] i_pw_key0,
  input wire logic [15:0] i_pw_key1,
  input wire logic i_pw_relock,
  // Read data from memory
  input wire logic i_rd_valid,
  input wire logic [15:0] i_rd_data,
  input wire logic [5:0] i_rd_check,
  input wire logic [1:0] i_prot_mode,
  input wire logic i_rd_flash,
  // Decode result
  output mmd_pkg::mmd_dec_t o_dec,
  output logic o_unlocked,
  // Checked read data
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output logic o_rd_error,
  output logic o_rd_corrected
);
  // Region lookup by descending start address
  function automatic mmd_pkg::mmd_tgt_t mmd_region(input logic [23:0] a);
    mmd_pkg::mmd_tgt_t t;
    if (a >= mmd_pkg::A_IMB) t = mmd_pkg::T_IMB;
    else if (a >= mmd_pkg::A_RSV_TOP) t = mmd_pkg::T_RSV;
    else if (a >= mmd_pkg::A_RSV_EP) t = mmd_pkg::T_RSV;
    else if (a >= mmd_pkg::A_EMULATED_PROGRAM_SRAM) t = mmd_pkg::T_EMULATED_PROGRAM_SRAM;
    else if (a >= mmd_pkg::A_RSV_PS) t = mmd_pkg::T_RSV;
    else if (a >= mmd_pkg::A_PROGRAM_SRAM) t = mmd_pkg::T_PROGRAM_SRAM;
    else if (a >= mmd_pkg::A_RSV_FL) t = mmd_pkg::T_RSV;
    else if (a >= mmd_pkg::A_FLASH) t = mmd_pkg::T_FLASH;
    else if (a >= mmd_pkg::A_EXT_MEM) t = mmd_pkg::T_EXT_MEM;
    else if (a >= mmd_pkg::A_EXT_IO) t = mmd_pkg::T_EXT_IO;
    else if (a >= mmd_pkg::A_RSV_P1) t = mmd_pkg::T_RSV;
    else if (a >= mmd_pkg::A_CAN_ALT) t = mmd_pkg::T_PERIPH;
    else if (a >= mmd_pkg::A_RSV_P0) t = mmd_pkg::T_RSV;
    else if (a >= mmd_pkg::A_CAN) t = mmd_pkg::T_PERIPH;
    else if (a >= mmd_pkg::A_EXT1) t = mmd_pkg::T_EXT_MEM;
    else if (a >= mmd_pkg::A_SREG) t = mmd_pkg::T_SREG;
    else if (a >= mmd_pkg::A_DUAL_PORT_RAM) t = mmd_pkg::T_DUAL_PORT_RAM;
    else if (a >= mmd_pkg::A_RSV_DP) t = mmd_pkg::T_RSV;
    else if (a >= mmd_pkg::A_EREG) t = mmd_pkg::T_EREG;
    else if (a >= mmd_pkg::A_XREG) t = mmd_pkg::T_XREG;
    else if (a >= mmd_pkg::A_DATA_SRAM) t = mmd_pkg::T_DATA_SRAM;
    else t = mmd_pkg::T_EXT_MEM;
    return t;
  endfunction : mmd_region

  logic [23:0] addr;
  mmd_pkg::mmd_tgt_t raw_tgt;
  mmd_pkg::mmd_tgt_t tgt_d;
  logic rsv_hit;
  logic seg0;
  logic prog_mem;
  logic fl_res_hit;
  logic [2:0] fl_module;
  logic [1:0] fl_cluster;
  logic [4:0] wp_idx;
  logic flash_wp_hit;
  logic program_sram_wp_hit;
  logic rd_prot_hit;
  logic blocked;
  logic [15:0] gpr_off;
  logic gpr_hit;
  logic dp_bit;
  logic sreg_bit;
  logic ereg_bit;
  logic ebc_d;
  logic sysbus_d;
  mmd_pkg::mmd_dec_t dec_d;
  mmd_pkg::mmd_dec_t dec_q;
  mmd_pkg::mmd_pw_t pw_d;
  mmd_pkg::mmd_pw_t pw_q;
  logic unlocked;
  logic [1:0] chk_mode;

  // Region decode of the linear address
  assign addr = i_req.addr;
  assign raw_tgt = mmd_region(addr); // R2 R24
  assign rsv_hit = (raw_tgt == mmd_pkg::T_RSV);
  assign seg0 = (addr[23:mmd_pkg::SEG_LSB] == 8'h00); // R4
  assign prog_mem = (raw_tgt == mmd_pkg::T_FLASH) || (raw_tgt == mmd_pkg::T_PROGRAM_SRAM) ||
                    (raw_tgt == mmd_pkg::T_EMULATED_PROGRAM_SRAM);

  // Flash module and cluster fields, cluster write-protect index
  assign fl_module = addr[mmd_pkg::FL_MOD_LSB +: 3]; // R20
  assign fl_cluster = addr[mmd_pkg::FL_CL_LSB +: 2]; // R16
  assign wp_idx = {fl_module, fl_cluster};

  // Protection checks
  assign fl_res_hit = (addr >= mmd_pkg::A_FL_RES) && (addr < mmd_pkg::A_FL_RES_END); // R14
  assign flash_wp_hit = i_req.write && (raw_tgt == mmd_pkg::T_FLASH) && i_flash_wp[wp_idx]; // R17
  assign program_sram_wp_hit = i_req.write && (raw_tgt == mmd_pkg::T_PROGRAM_SRAM) &&
                        (addr[16:0] < i_program_sram_wp_top); // R15
  assign rd_prot_hit = (raw_tgt == mmd_pkg::T_FLASH) && !i_req.fetch && !i_req.write &&
                       i_flash_rd_prot && !unlocked; // R19
  assign blocked = fl_res_hit || flash_wp_hit || program_sram_wp_hit || rd_prot_hit;

  // Final target: exactly one per access
  assign tgt_d = blocked ? mmd_pkg::T_NONE : // R24
                 rsv_hit ? (i_has_ext_bus ? mmd_pkg::T_EXT_MEM : mmd_pkg::T_NONE) : // R12
                 raw_tgt;

  // Register bank of the active context
  assign gpr_off = addr[15:0] - i_context_ptr;
  assign gpr_hit = seg0 && (raw_tgt == mmd_pkg::T_DUAL_PORT_RAM) && (gpr_off < mmd_pkg::GPR_SPAN); // R7

  // Bit-addressable windows
  assign dp_bit = (addr >= mmd_pkg::A_DP_BIT) && (addr < mmd_pkg::A_SREG); // R5
  assign sreg_bit = (addr >= mmd_pkg::A_SREG_BIT) && (addr < mmd_pkg::A_EXT1); // R5
  assign ereg_bit = (addr >= mmd_pkg::A_EREG_BIT) && (addr < mmd_pkg::A_RSV_DP); // R5

  // Routing between the two units and the system bus
  assign ebc_d = (tgt_d == mmd_pkg::T_PERIPH) || (tgt_d == mmd_pkg::T_EXT_MEM) ||
                 (tgt_d == mmd_pkg::T_EXT_IO); // R11
  assign sysbus_d = (tgt_d != mmd_pkg::T_NONE) &&
                    (i_req.fetch ? !prog_mem : (prog_mem || ebc_d)); // R10

  // Assemble the decode result
  always_comb begin
    dec_d = '0;
    dec_d.valid = i_req.valid;
    dec_d.target = tgt_d;
    dec_d.fault = (tgt_d == mmd_pkg::T_NONE);
    dec_d.via_pmu = i_req.fetch; // R8 R9
    dec_d.sysbus = sysbus_d;
    dec_d.via_ebc = ebc_d;
    dec_d.no_pipe_opt = (tgt_d == mmd_pkg::T_EXT_IO); // R13
    dec_d.bit_addr = dp_bit || sreg_bit || ereg_bit || gpr_hit; // R5 R6
    dec_d.gpr_hit = gpr_hit;
    dec_d.gpr_idx = gpr_off[4:1]; // R7
    dec_d.gpr_hi = gpr_off[0];
    dec_d.word = i_req.word; // R3
    dec_d.segment = addr[mmd_pkg::SEG_LSB +: 8]; // R1
    dec_d.page = addr[mmd_pkg::PAGE_LSB +: 2]; // R1
    dec_d.fl_module = fl_module;
    dec_d.fl_sector = addr[mmd_pkg::FL_SEC_LSB +: 6]; // R16
    dec_d.fl_block = addr[mmd_pkg::FL_BLK_LSB +: 5]; // R17
    dec_d.fl_line = addr[23:mmd_pkg::FL_LINE_LSB]; // R18
  end

  // Decode register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d; // R24
    end
  end

  assign o_dec = dec_q;

  // Password sequence for read protection
  always_comb begin
    pw_d = pw_q;
    case (pw_q)
      mmd_pkg::PW_LOCKED: begin
        if (i_pw_valid && i_pw_data == i_pw_key0) pw_d = mmd_pkg::PW_HALF;
      end
      mmd_pkg::PW_HALF: begin
        if (i_pw_relock) pw_d = mmd_pkg::PW_LOCKED;
        else if (i_pw_valid) pw_d = (i_pw_data == i_pw_key1) ? mmd_pkg::PW_OPEN : mmd_pkg::PW_LOCKED; // R19
      end
      mmd_pkg::PW_OPEN: begin
        if (i_pw_relock) pw_d = mmd_pkg::PW_LOCKED;
      end
      default: pw_d = mmd_pkg::PW_LOCKED;
    endcase
  end

  // Unlock state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pw_q <= mmd_pkg::PW_LOCKED;
    end else begin
      pw_q <= pw_d;
    end
  end

  assign unlocked = (pw_q == mmd_pkg::PW_OPEN);
  assign o_unlocked = unlocked;

  // Flash reads are always corrected
  assign chk_mode = i_rd_flash ? mmd_pkg::PROT_ECC : i_prot_mode; // R18

  // Parity and ECC check of read data
  mmd_mem_check u_check (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_rd_valid),
    .i_data(i_rd_data),
    .i_check(i_rd_check),
    .i_mode(chk_mode),
    .o_valid(o_rd_valid),
    .o_data(o_rd_data),
    .o_error(o_rd_error),
    .o_corrected(o_rd_corrected)
  );

  // Result follows request by one cycle
  AST_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst) // R24
    i_req.valid |=> o_dec.valid && $onehot(o_dec.target))
    else $error("decode not one-hot one cycle later");
  // Reserved flash sector refused
  AST_FL_RES: assert property (@(posedge i_clk) disable iff (i_rst) // R14
    i_req.valid && addr >= 24'hc0f000 && addr <= 24'hc0ffff |=> o_dec.fault && o_dec.target == mmd_pkg::T_NONE)
    else $error("reserved flash sector reachable");
  // Protected program SRAM writes refused
  AST_PROGRAM_SRAM_WP: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    i_req.valid && i_req.write && raw_tgt == mmd_pkg::T_PROGRAM_SRAM && addr[16:0] < i_program_sram_wp_top |=> o_dec.fault)
    else $error("protected program SRAM write passed");
  // Fetches use the program unit, data the data unit
  AST_UNIT: assert property (@(posedge i_clk) disable iff (i_rst) // R8 R9
    i_req.valid |=> o_dec.via_pmu == $past(i_req.fetch))
    else $error("wrong management unit");
  // External IO turns off pipeline optimizations
  AST_EXT_IO: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    o_dec.valid |-> o_dec.no_pipe_opt == (o_dec.target == mmd_pkg::T_EXT_IO))
    else $error("pipeline flag wrong for IO area");
  // CAN and serial ranges reach the peripheral bus
  AST_PERIPH: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    i_req.valid && addr >= 24'h200000 && addr <= 24'h2067ff |=> o_dec.target == mmd_pkg::T_PERIPH && o_dec.via_ebc)
    else $error("peripheral range not forwarded");
  // Reserved area becomes external when a bus exists
  AST_RSV: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    i_req.valid && rsv_hit && !blocked && i_has_ext_bus |=> o_dec.target == mmd_pkg::T_EXT_MEM)
    else $error("reserved access not external");
  // Internal data areas sit in segment 0
  AST_SEG0: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    o_dec.valid && (o_dec.target == mmd_pkg::T_DUAL_PORT_RAM || o_dec.target == mmd_pkg::T_SREG ||
    o_dec.target == mmd_pkg::T_DATA_SRAM) |-> o_dec.segment == 8'h00)
    else $error("data area outside segment 0");
  // Top DUAL_PORT_RAM bytes are bit-addressable
  AST_BIT: assert property (@(posedge i_clk) disable iff (i_rst) // R5 R6
    i_req.valid && (dp_bit || gpr_hit) |=> o_dec.bit_addr)
    else $error("bit window not flagged");
  // Two correct password words unlock
  AST_PW: assert property (@(posedge i_clk) disable iff (i_rst) // R19
    pw_q == mmd_pkg::PW_LOCKED && i_pw_valid && i_pw_data == i_pw_key0 ##1
    i_pw_valid && !i_pw_relock && i_pw_data == i_pw_key1 |=> o_unlocked)
    else $error("password did not unlock");
endmodule : mmd_decoder

// ==== bench/mmd_core_model.sv ====
`timescale 1ns/1ps
module mmd_core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Command from the bench
  input wire logic i_go,
  input wire mmd_pkg::mmd_req_t i_cmd,
  // Request to the decoder
  output mmd_pkg::mmd_req_t o_req
);
  // Register areas that software only reads
  wire reg_area = i_cmd.addr inside {[24'h00e000:24'h00f1ff], [24'h00fe00:24'h00ffff], [24'hffff00:24'hffffff]};

  // Request launched after the edge, address scrambled when idle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_req <= '0;
    end else if (i_go) begin
      o_req <= i_cmd;
      o_req.valid <= 1'b1;
      if (reg_area) begin
        o_req.write <= 1'b0;
      end
    end else begin
      o_req.valid <= 1'b0;
      o_req.addr <= ~o_req.addr;
    end
  end
endmodule : mmd_core_model

// ==== bench/mmd_decoder_test.sv ====
`timescale 1ns/1ps
module mmd_decoder_test;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, ext = 1'b0, rdprot = 1'b0;
  mmd_pkg::mmd_req_t cmd = '0, req;
  logic [15:0] cp = 16'hf600, key0 = 16'h5a3c, key1 = 16'hc3a5, pw_data = '0, rd_data = '0;
  logic [16:0] wp_top = '0;
  logic [27:0] fwp = '0;
  logic pw_valid = 1'b0, relock = 1'b0, rd_valid = 1'b0, rd_flash = 1'b0, unl_e = 1'b0;
  logic [5:0] rd_check = '0;
  logic [1:0] mode = '0;
  logic [23:0] s = 24'h018136;
  mmd_pkg::mmd_dec_t dec;
  logic unl, o_vld, o_err, o_cor;
  logic [15:0] o_dat;
  int n_mismatch = 0, n_compared = 0;
  localparam logic [23:0] CORN [28] = '{24'h00f600, 24'h00fd00, 24'h00fe00, 24'h00ff00, 24'h00f100, 24'h00f200,
    24'hc0efff, 24'hc0f000, 24'hc0ffff, 24'hc10000, 24'h203fff, 24'h204000, 24'h2067ff, 24'h206800, 24'h20c000,
    24'h210000, 24'h3fffff, 24'h400000, 24'hd8ffff, 24'hd90000, 24'he1bfff, 24'he1c000, 24'he9bfff, 24'he9c000,
    24'hffff00, 24'hfffeff, 24'he000ff, 24'he00100};

  // Clock
  always #20 clk = ~clk;

  mmd_core_model core (.i_clk(clk), .i_rst(rst), .i_go(go), .i_cmd(cmd), .o_req(req));
  mmd_decoder uut (.i_clk(clk), .i_rst(rst), .i_req(req), .i_context_ptr(cp), .i_has_ext_bus(ext),
    .i_program_sram_wp_top(wp_top), .i_flash_wp(fwp), .i_flash_rd_prot(rdprot), .i_pw_valid(pw_valid),
    .i_pw_data(pw_data), .i_pw_key0(key0), .i_pw_key1(key1), .i_pw_relock(relock), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .i_rd_check(rd_check), .i_prot_mode(mode), .i_rd_flash(rd_flash), .o_dec(dec),
    .o_unlocked(unl), .o_rd_valid(o_vld), .o_rd_data(o_dat), .o_rd_error(o_err), .o_rd_corrected(o_cor));

  function automatic logic [23:0] lfsr(input logic [23:0] v);
    return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
  endfunction : lfsr

  // Region of an address in the linear map
  function automatic mmd_pkg::mmd_tgt_t region(input logic [23:0] a);
    if (a < 24'h008000) return mmd_pkg::T_EXT_MEM;
    if (a < 24'h00e000) return mmd_pkg::T_DATA_SRAM;
    if (a < 24'h00f000) return mmd_pkg::T_XREG;
    if (a < 24'h00f200) return mmd_pkg::T_EREG;
    if (a < 24'h00f600) return mmd_pkg::T_RSV;
    if (a < 24'h00fe00) return mmd_pkg::T_DUAL_PORT_RAM;
    if (a < 24'h010000) return mmd_pkg::T_SREG;
    if (a < 24'h200000) return mmd_pkg::T_EXT_MEM;
    if (a < 24'h206800) return mmd_pkg::T_PERIPH;
    if (a < 24'h208000) return mmd_pkg::T_RSV;
    if (a < 24'h20c000) return mmd_pkg::T_PERIPH;
    if (a < 24'h210000) return mmd_pkg::T_RSV;
    if (a < 24'h400000) return mmd_pkg::T_EXT_IO;
    if (a < 24'hc00000) return mmd_pkg::T_EXT_MEM;
    if (a < 24'hd90000) return mmd_pkg::T_FLASH;
    if (a < 24'he00000) return mmd_pkg::T_RSV;
    if (a < 24'he1c000) return mmd_pkg::T_PROGRAM_SRAM;
    if (a < 24'he80000) return mmd_pkg::T_RSV;
    if (a < 24'he9c000) return mmd_pkg::T_EMULATED_PROGRAM_SRAM;
    if (a < 24'hffff00) return mmd_pkg::T_RSV;
    return mmd_pkg::T_IMB;
  endfunction : region

  // Hamming check bits of a data word
  function automatic logic [4:0] ham(input logic [15:0] d);
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < 16; i++) begin
      if (d[i]) c ^= mmd_pkg::HAM_POS[i];
    end
    return c;
  endfunction : ham

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // Decode result against the map and the protection settings
  task automatic expect_dec(input mmd_pkg::mmd_req_t r);
    mmd_pkg::mmd_tgt_t t;
    logic [23:0] a;
    logic [15:0] off;
    logic blk, pm, eb, general_purpose_register, bit_e;
    a = r.addr;
    t = region(a);
    off = a[15:0] - cp;
    pm = t inside {mmd_pkg::T_FLASH, mmd_pkg::T_PROGRAM_SRAM, mmd_pkg::T_EMULATED_PROGRAM_SRAM};
    eb = t inside {mmd_pkg::T_EXT_MEM, mmd_pkg::T_EXT_IO, mmd_pkg::T_PERIPH, mmd_pkg::T_RSV};
    blk = (a inside {[24'hc0f000:24'hc0ffff]}) || (t == mmd_pkg::T_RSV && !ext)
      || (t == mmd_pkg::T_FLASH && r.write && fwp[{a[20:18], a[17:16]}])
      || (t == mmd_pkg::T_PROGRAM_SRAM && r.write && a[16:0] < wp_top)
      || (t == mmd_pkg::T_FLASH && !r.fetch && !r.write && rdprot && !unl_e);
    general_purpose_register = t == mmd_pkg::T_DUAL_PORT_RAM && off < 16'h0020;
    bit_e = general_purpose_register || a inside {[24'h00fd00:24'h00fdff], [24'h00ff00:24'h00ffff], [24'h00f100:24'h00f1ff]};
    check(32'(dec.valid), 32'h1);
    check(32'(dec.fault), 32'(blk));
    if (blk || t != mmd_pkg::T_RSV) check(32'(dec.target), 32'(blk ? mmd_pkg::T_NONE : t));
    if (!blk && (t == mmd_pkg::T_RSV || t == mmd_pkg::T_PERIPH)) check(32'(dec.via_ebc), 32'h1);
    check(32'(dec.no_pipe_opt), 32'(t == mmd_pkg::T_EXT_IO));
    check(32'(dec.sysbus), 32'(!blk && (r.fetch ? !pm : (pm || eb))));
    if (!blk && r.fetch) check(32'(dec.via_pmu), 32'h1);
    if (t == mmd_pkg::T_DATA_SRAM && !r.fetch) check(32'(dec.via_pmu), 32'h0);
    check(32'(dec.bit_addr), 32'(bit_e));
    check(32'(dec.gpr_hit), 32'(general_purpose_register));
    if (general_purpose_register) check(32'({dec.gpr_idx, dec.gpr_hi}), 32'(off[4:0]));
    check(32'({dec.segment, dec.page, dec.word}), 32'({a[23:14], r.word}));
    if (t == mmd_pkg::T_FLASH && !blk)
      check(32'({dec.fl_module, dec.fl_sector, dec.fl_block}), 32'(a[20:7]));
    if (t == mmd_pkg::T_FLASH && !blk) check(32'(dec.fl_line), 32'(a[23:4]));
  endtask : expect_dec

  task automatic access(input logic f, input logic w, input logic wd, input logic [23:0] a);
    mmd_pkg::mmd_req_t r;
    @(posedge clk);
    cmd <= {1'b1, f, w, wd, a};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1 r = req;
    @(posedge clk);
    #1 expect_dec(r);
  endtask : access

  task automatic pw(input logic [15:0] d);
    @(posedge clk);
    pw_valid <= 1'b1;
    pw_data <= d;
  endtask : pw

  task automatic pw_end(input logic e);
    @(posedge clk);
    pw_valid <= 1'b0;
    unl_e = e;
    #1 check(32'(unl), 32'(e));
  endtask : pw_end

  task automatic rdchk(input logic [15:0] d, input logic [5:0] c, input logic [1:0] m, input logic f,
      input logic [15:0] ed, input logic ee, input logic ec);
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_data <= d;
    rd_check <= c;
    mode <= m;
    rd_flash <= f;
    @(posedge clk);
    rd_valid <= 1'b0;
    rd_data <= ~d;
    #1 check(32'({o_vld, o_dat, o_err, o_cor}), 32'({1'b1, ed, ee, ec}));
  endtask : rdchk

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [15:0] d, e1;
    logic [5:0] c;
    logic [3:0] j;
    logic [23:0] a;
    @(posedge clk);
    #1 check(32'(dec), 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    wp_top <= 17'h00100;
    fwp <= 28'h0000001;
    // Boundaries of most areas (not data SRAM, XREG, the A_EXT1 range or the A_CAN_ALT range), fetch, read and write, both bus options
    for (int i = 0; i < 28; i++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        ext <= k[0];
        access(k == 2, k == 3, k[0], CORN[i]);
      end
    end
    // Read protection and password unlock
    @(posedge clk);
    rdprot <= 1'b1;
    access(1'b0, 1'b0, 1'b1, 24'hc40010);
    access(1'b1, 1'b0, 1'b1, 24'hc40010);
    pw(key0);
    pw(key1);
    pw_end(1'b1);
    access(1'b0, 1'b0, 1'b0, 24'hd40022);
    @(posedge clk);
    relock <= 1'b1;
    @(posedge clk);
    relock <= 1'b0;
    unl_e = 1'b0;
    #1 check(32'(unl), 32'h0);
    pw(key0);
    pw(key0 ^ 16'h0100);
    pw(key1);
    pw_end(1'b0);
    // Random traffic with random configuration
    for (int n = 0; n < 400; n++) begin
      s = lfsr(s);
      a = lfsr(s);
      @(posedge clk);
      cp <= 16'hf600 + {5'h0, a[10:1], 1'b0};
      ext <= s[5];
      rdprot <= s[4];
      fwp <= {s[3:0], a};
      wp_top <= {1'b0, s[23:8]};
      if (n == 200) begin
        pw(key0);
        pw(key1);
        pw_end(1'b1);
      end
      @(posedge clk);
      case (s[2:0])
        3'h1: a = {8'h00, a[15:0]};
        3'h2: a = {8'h20, a[15:0]};
        3'h3: a = 24'hc00000 + {3'h0, a[20:0]};
        3'h4: a = {4'he, a[19:0]};
        3'h5: a = {12'h00f, a[11:0]};
        3'h6: a = {8'h00, cp + {10'h0, a[5:0]}};
        default: a = a;
      endcase
      access(s[6], s[7] & ~s[6], s[8], a);
    end
    // Parity and error correction of memory words
    for (int n = 0; n < 8; n++) begin
      d = '0;
      for (int k = 0; k < 50; k++) begin
        s = lfsr(s);
        d = s[15:0];
        if (^ham(d) == 1'b0) break;
      end
      j = s[19:16];
      c = {^d, ham(d)};
      e1 = d ^ (16'h0001 << j);
      rdchk(d, c, mmd_pkg::PROT_ECC, 1'b0, d, 1'b0, 1'b0);
      rdchk(e1, c, mmd_pkg::PROT_ECC, 1'b0, d, 1'b0, 1'b1);
      rdchk(e1 ^ (16'h0001 << (j + 4'h1)), c, mmd_pkg::PROT_ECC, 1'b0, 16'h0000, 1'b1, 1'b0);
      rdchk(d, c, mmd_pkg::PROT_PAR, 1'b0, d, 1'b0, 1'b0);
      rdchk(e1, c, mmd_pkg::PROT_PAR, 1'b0, 16'h0000, 1'b1, 1'b0);
      rdchk(e1, c, {n[0], n[0]}, 1'b0, e1, 1'b0, 1'b0);
      rdchk(e1, c, {n[0], n[0]}, 1'b1, d, 1'b0, 1'b1);
    end
    close_out();
  end
endmodule : mmd_decoder_test
